//--- include/dmacw_consts.svh
// constants for the dma channel control word block
`ifndef DMACW_CONSTS_SVH
`define DMACW_CONSTS_SVH

// ----------------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------------
`define DMACW_AW 8
`define DMACW_DW 32
`define DMACW_RESP_OKAY 2'h0
`define DMACW_RESP_SLVERR 2'h2

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define DMACW_OFF_PRI 8'h00
`define DMACW_OFF_ALT 8'h04
`define DMACW_OFF_CTRL 8'h08
`define DMACW_OFF_STAT 8'h0c

// ----------------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------------
`define DMACW_MODE_LSB 0
`define DMACW_MODE_MSB 2
`define DMACW_NB_BIT 3
`define DMACW_CNT_LSB 4
`define DMACW_CNT_MSB 13
`define DMACW_ARB_LSB 14
`define DMACW_ARB_MSB 17

// ----------------------------------------------------------------------
// arbitration size decode
// ----------------------------------------------------------------------
`define DMACW_ARB_CAP_CODE 4'ha
`define DMACW_ARB_FULL 11'h400

// ----------------------------------------------------------------------
// ctrl and status bits, reset values
// ----------------------------------------------------------------------
`define DMACW_CTRL_EN 0
`define DMACW_CTRL_SWREQ 1
`define DMACW_CTRL_BOCLR 2
`define DMACW_ST_BUSY 0
`define DMACW_ST_ALT 1
`define DMACW_ST_BO 2
`define DMACW_ST_SINGLE 3
`define DMACW_ST_REM_LSB 4
`define DMACW_ST_REM_MSB 14
`define DMACW_RST_DATA 32'h0000_0000

`endif

//--- include/dmacw_pkg.sv
// types shared by the dma channel control word block
package dmacw_pkg;

  // ----------------------------------------------------------------------
  // engine states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_WAIT,
    ST_MOVE,
    ST_WB
  } dmacw_state_t;

  // ----------------------------------------------------------------------
  // cycle modes, listed in encoding order starting at zero
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_STOP,
    MODE_BASIC,
    MODE_AUTO,
    MODE_PINGPONG,
    MODE_MEM_SG,
    MODE_ALT_MEM_SG,
    MODE_PER_SG,
    MODE_ALT_PER_SG
  } dmacw_mode_t;

endpackage

//--- core/dmacw_buf2.sv
// two-entry valid/ready buffer in the data path
`timescale 1ns/1ps
`include "dmacw_consts.svh"

module dmacw_buf2 (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // filling side
  input wire logic [`DMACW_DW-1:0] i_in_data,
  input wire logic i_in_valid,
  output logic o_in_ready,
  output logic o_full_next,
  // draining side
  output logic [`DMACW_DW-1:0] o_out_data,
  output logic o_out_valid,
  input wire logic i_out_ready
);

  logic [`DMACW_DW-1:0] head_reg, head_next, tail_reg, tail_next;
  logic hv_reg, hv_next, tv_reg, tv_next;
  logic push, pop;

  // head always holds the oldest word, so the output is a plain flop
  always_comb begin
    push = i_in_valid & ~tv_reg;
    pop = hv_reg & i_out_ready;
    hv_next = hv_reg;
    tv_next = tv_reg;
    head_next = head_reg;
    tail_next = tail_reg;
    if (pop) begin
      if (tv_reg) begin
        head_next = tail_reg;
        tv_next = 1'b0;
      end else begin
        hv_next = 1'b0;
      end
    end
    if (push) begin
      if (!hv_next) begin
        head_next = i_in_data;
        hv_next = 1'b1;
      end else begin
        tail_next = i_in_data;
        tv_next = 1'b1;
      end
    end
  end

  // storage and occupancy
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      head_reg <= `DMACW_RST_DATA;
      tail_reg <= `DMACW_RST_DATA;
      hv_reg <= 1'b0;
      tv_reg <= 1'b0;
    end else begin
      head_reg <= head_next;
      tail_reg <= tail_next;
      hv_reg <= hv_next;
      tv_reg <= tv_next;
    end
  end

  assign o_in_ready = ~tv_reg;
  assign o_full_next = tv_next; // lets the source side stall a cycle early
  assign o_out_data = head_reg;
  assign o_out_valid = hv_reg;

endmodule // dmacw_buf2

//--- core/dmacw_top.sv
// dma channel engine driven by a software-written control word
// Function
// - code 9 is 512, codes a-f are 1024
// - count field bits 13:4 holds items minus one
// - count is items of data size, not bytes
// - write back outstanding count before each arbitration
// - short final transfer uses singles without next-burst
// - next-burst bit forces burst-only for final transfer in peripheral scatter-gather mode
// - control word has no reset value
// - mode field selects the cycle; zero stops
// - codes 0 to 8 give two to the code
// - basic mode needs a request per arbitration
// - auto-request mode needs only the first request
// - ping-pong alternates structures until invalid or changed
`timescale 1ns/1ps
`include "dmacw_consts.svh"

module dmacw_top (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // axi4-lite write address
  input wire logic [`DMACW_AW-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  // axi4-lite write data
  input wire logic [`DMACW_DW-1:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // axi4-lite write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read address
  input wire logic [`DMACW_AW-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  // axi4-lite read data
  output logic [`DMACW_DW-1:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // peripheral request
  input wire logic i_req,
  // source item stream
  input wire logic [`DMACW_DW-1:0] i_src_data,
  input wire logic i_src_valid,
  output logic o_src_ready,
  // destination item stream
  output logic [`DMACW_DW-1:0] o_dst_data,
  output logic o_dst_valid,
  input wire logic i_dst_ready,
  // channel status
  output logic o_busy,
  output logic o_single_xfer,
  output logic o_burst_only,
  output logic o_done
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  dmacw_pkg::dmacw_state_t state_reg, state_next;
  dmacw_pkg::dmacw_mode_t mode;
  logic [31:0] word_reg [0:1];
  logic [31:0] cur_word;
  logic alt_sel_reg, enable_reg, first_reg, req_pend_reg;
  logic burst_only_reg, single_reg, done_reg, busy_reg;
  logic [10:0] remain_reg, period_reg, arb_n, period_load;
  logic [3:0] arb_code;
  logic last_short, use_burst, bo_set, need_req, go;
  logic aw_held_reg, w_held_reg, awready_reg, wready_reg, bvalid_reg;
  logic aw_held_next, w_held_next, aw_take, w_take, wr_fire;
  logic [`DMACW_AW-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic arready_reg, rvalid_reg, rvalid_next, ar_take;
  logic [31:0] rdata_reg;
  logic ctrl_wr, word_wr, wb_fire, accept, src_rdy_reg;
  logic buf_in_ready, buf_full_next;

  // byte-lane merge for word registers
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // control word decode
  // ----------------------------------------------------------------------
  assign cur_word = word_reg[alt_sel_reg];
  assign mode = dmacw_pkg::dmacw_mode_t'(
    cur_word[`DMACW_MODE_MSB:`DMACW_MODE_LSB]);
  assign arb_code = cur_word[`DMACW_ARB_MSB:`DMACW_ARB_LSB];

  // arbitration size as an item count; shift stays below 1024
  always_comb begin
    if (arb_code >= `DMACW_ARB_CAP_CODE) begin
      arb_n = `DMACW_ARB_FULL;
    end else begin
      arb_n = 11'(11'h001 << arb_code);
    end
  end

  // period sizing for the next arbitration
  always_comb begin
    last_short = remain_reg < arb_n;
    bo_set = (state_reg == dmacw_pkg::ST_WAIT) && last_short &&
             (mode == dmacw_pkg::MODE_PER_SG) &&
             cur_word[`DMACW_NB_BIT];
    use_burst = burst_only_reg | bo_set;
    if (!last_short) begin
      period_load = arb_n;
    end else if (use_burst) begin
      period_load = remain_reg; // one burst for the rest
    end else begin
      period_load = 11'h001; // single transfers
    end
    need_req = first_reg || (mode != dmacw_pkg::MODE_AUTO);
    go = !need_req || req_pend_reg;
  end

  // ----------------------------------------------------------------------
  // engine state machine
  // ----------------------------------------------------------------------
  // one accepted handshake on the source is one item of the data size
  assign accept = src_rdy_reg & i_src_valid & buf_in_ready;
  assign wb_fire = state_reg == dmacw_pkg::ST_WB;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      dmacw_pkg::ST_IDLE: begin
        if (enable_reg) begin
          state_next = dmacw_pkg::ST_LOAD;
        end
      end
      dmacw_pkg::ST_LOAD: begin
        if (mode == dmacw_pkg::MODE_STOP) begin
          state_next = dmacw_pkg::ST_IDLE; // stopped or invalid
        end else begin
          state_next = dmacw_pkg::ST_WAIT;
        end
      end
      dmacw_pkg::ST_WAIT: begin
        if (go) begin
          state_next = dmacw_pkg::ST_MOVE;
        end
      end
      dmacw_pkg::ST_MOVE: begin
        if (accept && period_reg == 11'h001) begin
          state_next = dmacw_pkg::ST_WB;
        end
      end
      dmacw_pkg::ST_WB: begin
        if (remain_reg != 11'h000) begin
          state_next = dmacw_pkg::ST_WAIT;
        end else if (mode == dmacw_pkg::MODE_PINGPONG) begin
          state_next = dmacw_pkg::ST_LOAD; // other structure next
        end else begin
          state_next = dmacw_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      state_reg <= dmacw_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // remaining and per-period counters
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      remain_reg <= 11'h000;
      period_reg <= 11'h000;
    end else if (state_reg == dmacw_pkg::ST_LOAD) begin
      remain_reg <= {1'b0, cur_word[`DMACW_CNT_MSB:`DMACW_CNT_LSB]} +
                    11'h001;
    end else if (state_reg == dmacw_pkg::ST_WAIT && go) begin
      period_reg <= period_load;
    end else if (accept) begin
      remain_reg <= remain_reg - 11'h001;
      period_reg <= period_reg - 11'h001;
    end
  end

  // first-period flag and structure select
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      first_reg <= 1'b0;
      alt_sel_reg <= 1'b0;
    end else begin
      if (state_reg == dmacw_pkg::ST_LOAD) begin
        first_reg <= 1'b1;
      end else if (state_reg == dmacw_pkg::ST_WAIT && go) begin
        first_reg <= 1'b0;
      end
      if (state_next == dmacw_pkg::ST_LOAD && wb_fire) begin
        alt_sel_reg <= ~alt_sel_reg;
      end
    end
  end

  // pending request; a new request in the consume cycle is kept
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      req_pend_reg <= 1'b0;
    end else begin
      req_pend_reg <= i_req |
        (ctrl_wr && w_strb_reg[0] && w_data_reg[`DMACW_CTRL_SWREQ]) |
        (req_pend_reg &
         ~(state_reg == dmacw_pkg::ST_WAIT && go && need_req));
    end
  end

  // burst-only bit: hardware set wins over the software clear
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      burst_only_reg <= 1'b0;
    end else if (bo_set) begin
      burst_only_reg <= 1'b1;
    end else if (ctrl_wr && w_strb_reg[0] &&
                 w_data_reg[`DMACW_CTRL_BOCLR]) begin
      burst_only_reg <= 1'b0;
    end
  end

  // channel enable: software set wins over hardware stop
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      enable_reg <= 1'b0;
    end else if (ctrl_wr && w_strb_reg[0]) begin
      enable_reg <= w_data_reg[`DMACW_CTRL_EN];
    end else if (state_next == dmacw_pkg::ST_IDLE &&
                 state_reg != dmacw_pkg::ST_IDLE) begin
      enable_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // control words: no reset, they behave like ram
  // ----------------------------------------------------------------------
  // bus writes are held off during write-back, so the two never collide
  always_ff @(posedge i_mclk) begin
    if (wb_fire && remain_reg != 11'h000) begin
      word_reg[alt_sel_reg][`DMACW_CNT_MSB:`DMACW_CNT_LSB] <=
        10'(remain_reg - 11'h001);
    end else if (word_wr) begin
      word_reg[aw_addr_reg[2]] <= merge(word_reg[aw_addr_reg[2]],
                                        w_data_reg, w_strb_reg);
    end
  end

  // ----------------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      src_rdy_reg <= 1'b0;
      busy_reg <= 1'b0;
      single_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      // ready drops a cycle early when the buffer will fill
      src_rdy_reg <= (state_next == dmacw_pkg::ST_MOVE) & ~buf_full_next;
      busy_reg <= state_next != dmacw_pkg::ST_IDLE;
      if ((state_reg == dmacw_pkg::ST_WAIT && go) || wb_fire) begin
        single_reg <= ~wb_fire & last_short & ~use_burst;
      end
      done_reg <= wb_fire && (state_next == dmacw_pkg::ST_IDLE);
    end
  end

  // ----------------------------------------------------------------------
  // data buffer
  // ----------------------------------------------------------------------
  dmacw_buf2 u_buf (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_in_data(i_src_data),
    .i_in_valid(src_rdy_reg & i_src_valid),
    .o_in_ready(buf_in_ready),
    .o_full_next(buf_full_next),
    .o_out_data(o_dst_data),
    .o_out_valid(o_dst_valid),
    .i_out_ready(i_dst_ready)
  );

  // ----------------------------------------------------------------------
  // axi4-lite write path
  // ----------------------------------------------------------------------
  always_comb begin
    aw_take = i_awvalid & awready_reg;
    w_take = i_wvalid & wready_reg;
    wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg & ~wb_fire;
    aw_held_next = (aw_held_reg & ~wr_fire) | aw_take;
    w_held_next = (w_held_reg & ~wr_fire) | w_take;
    ctrl_wr = wr_fire && aw_addr_reg[7:2] == `DMACW_OFF_CTRL >> 2;
    word_wr = wr_fire && (aw_addr_reg[7:2] == `DMACW_OFF_PRI >> 2 ||
                          aw_addr_reg[7:2] == `DMACW_OFF_ALT >> 2);
  end

  // write handshakes and response
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `DMACW_RESP_OKAY;
      aw_addr_reg <= '0;
      w_data_reg <= `DMACW_RST_DATA;
      w_strb_reg <= 4'h0;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awready_reg <= ~aw_held_next;
      wready_reg <= ~w_held_next;
      if (aw_take) begin
        aw_addr_reg <= i_awaddr;
      end
      if (w_take) begin
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= (ctrl_wr || word_wr) ? `DMACW_RESP_OKAY :
                                            `DMACW_RESP_SLVERR;
      end else if (i_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // axi4-lite read path
  // ----------------------------------------------------------------------
  assign ar_take = i_arvalid & arready_reg;
  assign rvalid_next = ar_take | (rvalid_reg & ~i_rready);

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= `DMACW_RST_DATA;
      rresp_reg <= `DMACW_RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      arready_reg <= ~rvalid_next;
      if (ar_take) begin
        rresp_reg <= `DMACW_RESP_OKAY;
        rdata_reg <= `DMACW_RST_DATA;
        unique case (i_araddr[7:2])
          `DMACW_OFF_PRI >> 2: rdata_reg <= word_reg[0];
          `DMACW_OFF_ALT >> 2: rdata_reg <= word_reg[1];
          `DMACW_OFF_CTRL >> 2: rdata_reg[`DMACW_CTRL_EN] <= enable_reg;
          `DMACW_OFF_STAT >> 2: begin
            rdata_reg[`DMACW_ST_BUSY] <= busy_reg;
            rdata_reg[`DMACW_ST_ALT] <= alt_sel_reg;
            rdata_reg[`DMACW_ST_BO] <= burst_only_reg;
            rdata_reg[`DMACW_ST_SINGLE] <= single_reg;
            rdata_reg[`DMACW_ST_REM_MSB:`DMACW_ST_REM_LSB] <= remain_reg;
          end
          default: rresp_reg <= `DMACW_RESP_SLVERR;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // output assignments
  // ----------------------------------------------------------------------
  assign o_awready = awready_reg;
  assign o_wready = wready_reg;
  assign o_bresp = bresp_reg;
  assign o_bvalid = bvalid_reg;
  assign o_arready = arready_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;
  assign o_rvalid = rvalid_reg;
  assign o_src_ready = src_rdy_reg;
  assign o_busy = busy_reg;
  assign o_single_xfer = single_reg;
  assign o_burst_only = burst_only_reg;
  assign o_done = done_reg;

endmodule // dmacw_top

//--- tb/dmacw_top_properties.sv
// port assertions for the dma control word block
`timescale 1ns/1ps
module dmacw_props (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // register bus
  input wire logic o_awready,
  input wire logic o_wready,
  input wire logic [1:0] o_bresp,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic i_rready,
  // stream and status
  input wire logic [31:0] o_dst_data,
  input wire logic o_dst_valid,
  input wire logic i_dst_ready,
  input wire logic o_single_xfer,
  input wire logic o_burst_only,
  input wire logic o_done
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  // a read is taken, then answered with the address channel shut
  sequence s_rd_taken;
    i_arvalid && o_arready;
  endsequence
  sequence s_rd_answer;
    o_rvalid && !o_arready;
  endsequence
  a_read_answer: assert property (s_rd_taken |=> s_rd_answer)
    else $error("read not answered next cycle");
  a_rdata_hold: assert property (o_rvalid && !i_rready |=>
    o_rvalid && $stable(o_rdata)) else $error("read data dropped");
  a_bresp_hold: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp)) else $error("write response dropped");
  // both channels reopen as the response goes out
  a_write_reopen: assert property ($rose(o_bvalid) |-> o_awready && o_wready)
    else $error("write channels not reopened with response");
  a_dst_hold: assert property (
    o_dst_valid && !i_dst_ready |=> o_dst_valid && $stable(o_dst_data))
    else $error("item lost under stall");
  a_done_pulse: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  a_single_burst: assert property (o_single_xfer |-> !o_burst_only)
    else $error("single transfer while burst only");
  // burst only falls solely through a software write
  a_bo_clear: assert property ($fell(o_burst_only) |-> o_bvalid)
    else $error("burst only cleared by hardware");
endmodule // dmacw_props

bind dmacw_top dmacw_props dmacw_props_i (.i_mclk, .i_rstn, .o_awready,
  .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_arvalid, .o_arready,
  .o_rdata, .o_rvalid, .i_rready, .o_dst_data, .o_dst_valid, .i_dst_ready,
  .o_single_xfer, .o_burst_only, .o_done);

//--- tb/dmacw_peer.sv
// stream partner: stalling item source and in-order item sink
`timescale 1ns/1ps
module dmacw_peer (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // source side
  input wire logic i_take,
  output logic [31:0] o_data,
  output logic o_valid,
  // sink side
  input wire logic [31:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  output int o_got,
  output int o_bad
);
  logic [31:0] nxt = 0;
  logic [31:0] want = 0;
  logic [3:0] cyc = 0;
  initial begin
    o_valid = 0;
    o_data = 0;
    o_ready = 0;
    o_got = 0;
    o_bad = 0;
  end
  // source: idle slot every fourth cycle, item held until taken
  always @(posedge i_mclk) begin
    cyc <= cyc + 4'h1;
    if (!i_rstn)
      o_valid <= 0;
    else if (o_valid && i_take) begin
      o_valid <= 0;
      o_data <= ~o_data; // released line shows no stale item
    end else if (!o_valid && cyc[1:0] != 2'h3) begin
      o_valid <= 1;
      o_data <= nxt;
      nxt <= nxt + 1;
    end
  end
  // sink: stalls four cycles in sixteen, checks word order
  always @(posedge i_mclk) begin
    o_ready <= i_rstn && cyc[3:2] != 2'h1;
    if (i_valid && o_ready) begin
      if (i_data !== want) o_bad <= o_bad + 1;
      want <= want + 1;
      o_got <= o_got + 1;
    end
  end
endmodule // dmacw_peer

//--- tb/test_dmacw_top.sv
// self-checking bench for the dma control word block
`timescale 1ns/1ps
module test_dmacw_top;
  logic i_mclk = 0, i_rstn = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  logic i_arvalid = 0, i_rready = 0, i_req = 0, i_src_valid, i_dst_ready;
  logic [7:0] i_awaddr = 0, i_araddr = 0;
  logic [31:0] i_wdata = 0, i_src_data, o_rdata, o_dst_data, d;
  logic [3:0] i_wstrb = 4'hf;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_src_ready;
  logic o_dst_valid, o_busy, o_single_xfer, o_burst_only, o_done;
  logic [1:0] o_bresp, o_rresp, r;
  logic saw_s, saw_b;
  int num_errors = 0, samples_checked = 0, cyc = 0, got, bad, g;

  dmacw_top dmacw_top_i (.i_mclk, .i_rstn, .i_awaddr, .i_awvalid, .o_awready,
    .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
    .i_rready, .i_req, .i_src_data, .i_src_valid, .o_src_ready, .o_dst_data,
    .o_dst_valid, .i_dst_ready, .o_busy, .o_single_xfer, .o_burst_only,
    .o_done);
  dmacw_peer dmacw_peer_i (.i_mclk, .i_rstn, .i_take(o_src_ready),
    .o_data(i_src_data), .o_valid(i_src_valid), .i_data(o_dst_data),
    .i_valid(o_dst_valid), .o_ready(i_dst_ready), .o_got(got), .o_bad(bad));

  always #10 i_mclk = ~i_mclk;
  // watch status levels and cut a hang short
  always @(posedge i_mclk) begin
    if (o_single_xfer === 1'b1) saw_s = 1;
    if (o_burst_only === 1'b1) saw_b = 1;
    cyc++;
    if (cyc == 95000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task report_and_stop;
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %0t saw %h want %h", $time, s, e);
    end
  endtask

  function logic [31:0] w(input logic [3:0] a, input logic [9:0] n,
    input logic nb, input logic [2:0] m);
    return {14'h0, a, n, nb, m};
  endfunction

  // one write; both channels held until each is taken
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_mclk);
    i_awaddr <= a;
    i_wdata <= v;
    i_awvalid <= 1;
    i_wvalid <= 1;
    i_bready <= 1;
    do begin
      @(posedge i_mclk);
      if (o_awready) i_awvalid <= 0;
      if (o_wready) i_wvalid <= 0;
    end while (o_bvalid !== 1'b1);
    r = o_bresp;
    i_bready <= 0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge i_mclk);
    i_araddr <= a;
    i_arvalid <= 1;
    i_rready <= 1;
    do begin
      @(posedge i_mclk);
      if (o_arready) i_arvalid <= 0;
    end while (o_rvalid !== 1'b1);
    d = o_rdata;
    r = o_rresp;
    i_rready <= 0;
  endtask

  // load both words, enable with a software request, count the items
  task run(input logic [31:0] p, input logic [31:0] a, input int n);
    g = got;
    saw_s = 0;
    saw_b = 0;
    wr(8'h00, p);
    wr(8'h04, a);
    wr(8'h08, 32'h3);
    while (o_done !== 1'b1) @(posedge i_mclk);
    repeat (12) @(posedge i_mclk);
    chk(got - g, n);
  endtask

  task t_regs;
    wr(8'h00, 32'h0);
    chk(32'(r), 32'h0);
    wr(8'h00, 32'hfffc_3ff8);
    rd(8'h00);
    chk(d, 32'hfffc_3ff8);
    rd(8'h10);
    chk({r, d[29:0]}, 32'h8000_0000);
    wr(8'h0c, 32'h1);
    chk(32'(r), 32'h2);
  endtask

  task t_stop;
    g = got;
    wr(8'h00, w(4'h0, 10'h3, 1'b0, 3'h0));
    wr(8'h08, 32'h3);
    repeat (10) @(posedge i_mclk);
    chk(o_busy, 0);
    rd(8'h08);
    chk(d[0], 0);
    chk(got - g, 0);
  endtask

  // basic mode parks after each period until a new request
  task t_basic;
    g = got;
    wr(8'h00, w(4'h0, 10'h1, 1'b0, 3'h1));
    wr(8'h08, 32'h3);
    repeat (40) @(posedge i_mclk);
    chk(got - g, 1);
    rd(8'h00);
    chk(d[13:4], 0);
    @(posedge i_mclk);
    i_req <= 1;
    @(posedge i_mclk);
    i_req <= 0;
    while (o_done !== 1'b1) @(posedge i_mclk);
    repeat (12) @(posedge i_mclk);
    chk(got - g, 2);
  endtask

  task t_auto;
    run(w(4'h1, 10'h4, 1'b0, 3'h2), 0, 5);
    chk(saw_s, 1);
    rd(8'h00);
    chk(d[13:4], 0);
  endtask

  // every arbitration code over a full 1024-item cycle
  task t_arb;
    for (int k = 0; k < 16; k++) begin
      run(w(k[3:0], 10'h3ff, 1'b0, 3'h2), 0, 1024);
      chk(saw_s, 0);
      rd(8'h00);
      chk(d[13:4], k < 10 ? (1 << k) - 1 : 1023);
    end
  endtask

  task t_burst;
    @(posedge i_mclk);
    i_req <= 1;
    run(w(4'h1, 10'h2, 1'b1, 3'h6), 0, 3);
    chk({saw_b, saw_s}, 2);
    wr(8'h08, 32'h4);
    rd(8'h0c);
    chk(d[2], 0);
    run(w(4'h1, 10'h2, 1'b0, 3'h6), 0, 3);
    chk({saw_b, saw_s}, 1);
  endtask

  task t_pingpong;
    run(w(4'h0, 10'h0, 1'b0, 3'h3), w(4'h0, 10'h0, 1'b0, 3'h2), 2);
    rd(8'h0c);
    chk(d[1], 1);
    i_req <= 0;
  endtask

  initial begin
    repeat (5) @(posedge i_mclk);
    i_rstn <= 1;
    t_regs();
    t_stop();
    t_basic();
    t_auto();
    t_arb();
    t_burst();
    t_pingpong();
    chk(bad, 0);
    report_and_stop();
  end
endmodule // test_dmacw_top
